// ### design/iac_pkg.sv
// shared constants and types of the auxiliary command decoder
`default_nettype none
package iac_pkg;

    // register byte offsets on the avalon slave
    localparam logic [3:0] ADDR_STATUS = 4'h0;   // address status, read only
    localparam logic [3:0] ADDR_AUXCMD = 4'h4;   // auxiliary command, write only
    localparam logic [3:0] ADDR_STATIC = 4'h8;   // static settings readback
    localparam logic [3:0] ADDR_PAGE   = 4'hc;   // page-in state readback

    // command register layout
    localparam int CMD_CS_BIT  = 7;
    localparam int CMD_RSV_MSB = 6;
    localparam int CMD_RSV_LSB = 5;
    localparam int CMD_FN_MSB  = 4;

    // function codes in bits 4..0
    localparam logic [4:0] FN_SWRST = 5'h00;
    localparam logic [4:0] FN_DAC   = 5'h01;
    localparam logic [4:0] FN_RHDF  = 5'h02;
    localparam logic [4:0] FN_HDFA  = 5'h03;
    localparam logic [4:0] FN_HDFE  = 5'h04;
    localparam logic [4:0] FN_NBAF  = 5'h05;
    localparam logic [4:0] FN_FGET  = 5'h06;
    localparam logic [4:0] FN_RTL   = 5'h07;
    localparam logic [4:0] FN_FEOI  = 5'h08;
    localparam logic [4:0] FN_LON   = 5'h09;
    localparam logic [4:0] FN_TON   = 5'h0a;
    localparam logic [4:0] FN_DAI   = 5'h13;
    localparam logic [4:0] FN_PTS   = 5'h14;
    localparam logic [4:0] FN_STDL  = 5'h15;
    localparam logic [4:0] FN_VSTDL = 5'h17;
    localparam logic [4:0] FN_SERVICE_REQUEST_BIT_TWO  = 5'h18;
    localparam logic [4:0] FN_ALT   = 5'h19;
    localparam logic [4:0] FN_REQ   = 5'h1a;
    localparam logic [4:0] FN_CHRST = 5'h1c;
    localparam logic [4:0] FN_IST   = 5'h1d;
    localparam logic [4:0] FN_PIA   = 5'h1e;
    localparam logic [4:0] FN_PIB   = 5'h1f;

    // address status bit positions
    localparam int ST_REM_BIT  = 7;
    localparam int ST_LLO_BIT  = 6;
    localparam int ST_ATN_BIT  = 5;
    localparam int ST_LPAS_BIT = 4;
    localparam int ST_TALKER_PRIMARY_ADDRESSED_BIT = 3;
    localparam int ST_LA_BIT   = 2;
    localparam int ST_TA_BIT   = 1;
    localparam int ST_ULPA_BIT = 0;

    // trigger stretch length in clock cycles
    localparam int         TRIG_CNT_W     = 3;
    localparam logic [2:0] TRIG_PULSE_CYC = 3'h5;

    // events from the bus addressing logic, strobes qualified by accept-data
    typedef struct packed {
        logic mta;        // own talk address accepted
        logic mla;        // own listen address accepted
        logic ota;        // other talk address accepted
        logic pcg;        // primary command group byte accepted
        logic unl;        // unlisten accepted
        logic ifc;        // interface clear level
        logic spas;       // serial poll active level
        logic prim_lsb;   // lsb of primary address, valid with pcg
        logic rem;
        logic llo;
        logic atn;
    } iac_evt_s;

    typedef struct packed {
        logic swrst;
        logic hdfa;
        logic hdfe;
        logic fget;
        logic rtl;
        logic lon;
        logic ton;
        logic dai;
        logic stdl;
        logic vstdl;
        logic service_request_bit_two;
        logic ist;
    } iac_static_s;

    localparam iac_static_s STATIC_RST = '{swrst: 1'b1, default: 1'b0};

    typedef struct packed {
        logic dac_invalid;
        logic dac_valid;
        logic rhdf;
        logic nbaf;
        logic feoi;
        logic rtl;
        logic pts;
        logic switch_alt_mode;
        logic reqf;
        logic reqt;
        logic chip_reset_cmd;
        logic clrpi;
        logic pagein_mask_two;
        logic pagein_bus_ctrl;
        logic pagein_eos;
        logic pagein_accessory;
    } iac_pulse_s;

    typedef struct packed {
        logic mask_two;
        logic bus_ctrl;
        logic eos;
        logic accessory;
    } iac_page_s;

    // whole state of the main module
    typedef struct packed {
        logic        avs_wait;
        logic [31:0] rdata;
        iac_static_s stat;
        iac_pulse_s  pulse;
        iac_page_s   page;
        logic        talker_primary_addressed;
        logic        lpas;
        logic        la;
        logic        ta;
        logic        ulpa;
    } iac_state_s;

    typedef struct packed {
        logic                  hold;
        logic                  trig;
        logic [TRIG_CNT_W-1:0] cnt;
    } iac_trig_s;

endpackage : iac_pkg
`default_nettype wire

// ### design/iac_trig_stretch.sv
// trigger output driver for the forced group execute trigger
`timescale 1ns/10ps
`default_nettype none
module iac_trig_stretch
    import iac_pkg::*;
(
    input  wire logic i_mclk,
    input  wire logic i_nrst,
    input  wire logic i_clk_en,
    input  wire logic i_set,
    input  wire logic i_clr,
    output logic      o_trig
);

    iac_trig_s st_q;
    iac_trig_s st_d;

    // set holds the trigger, clear gives a fixed-length pulse
    always_comb
    begin
        st_d = st_q;
        if (i_set)
        begin
            st_d.hold = 1'b1;
            st_d.trig = 1'b1;
            st_d.cnt  = '0;
        end
        else if (i_clr)
        begin
            st_d.hold = 1'b0;
            st_d.trig = 1'b1;
            st_d.cnt  = TRIG_PULSE_CYC - 3'h1;    // counts the first cycle too
        end
        else if (st_q.cnt != '0)
            st_d.cnt = st_q.cnt - 3'h1;
        else if (!st_q.hold)
            st_d.trig = 1'b0;
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
            st_q <= '0;
        else if (i_clk_en)
            st_q <= st_d;
    end

    assign o_trig = st_q.trig;

endmodule : iac_trig_stretch
`default_nettype wire

// ### design/iac_aux_cmd.sv
// auxiliary command decoder and address status register
`timescale 1ns/10ps
`default_nettype none
// Contract
// - talk-primary flag sets on own talk address, clears on other primary byte or pon
// - listener flag reads 1 when addressed to listen or in listen-only
// - becoming addressed to listen drops any talker-addressed condition
// - listener flag clears on pon, interface clear, or accepted unlisten
// - talker flag reads 1 when addressed to talk, serial polled or talk-only
// - becoming addressed to talk drops any listener-addressed condition
// - talker flag clears on pon, interface clear, or other talk address accepted
// - status bit 0 holds lsb of last received primary address
// - chip reset code 1c is pulsed and clears the primary lsb flag
// - command bit 7 sets or clears, bits 4..0 select the function
// - pulsed commands assert their action for exactly one clock
// - 01 and 81 release accept holdoff, secondary invalid or valid
// - 05 pulses byte-available false, 08 pulses end-or-identify request
// - 06/86 forced trigger, 07/87 return-to-local message
// - 13/93 globally disable interrupts
// - 15/95 short settling, 17/97 very short settling, static
// - 18/98 second service bit; 1a/9a service request pulses; 1d/9d poll flag
// - 1e, 1f, 9e, 9f page registers in; 9c clears all page-ins
// - undefined command codes take no action
// - software reset holds interface functions idle like power-on
// - clearing forced trigger pulses trigger five clocks; setting holds it
module iac_aux_cmd
    import iac_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    input  wire logic        i_clk_en,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire iac_evt_s    i_evt,
    output iac_static_s      o_static,
    output iac_pulse_s       o_pulse,
    output iac_page_s        o_page,
    output logic             o_trigger
);

    iac_state_s st_q;
    iac_state_s st_d;

    logic       wr_cmd;
    logic [7:0] cmd;
    logic       cs;
    logic [4:0] fn;
    logic       rsv_ok;
    logic       pon;
    logic       la_flag;
    logic       ta_flag;
    logic       fget_set;
    logic       fget_clr;
    logic [7:0] status;

    // command strobe: a write is acted on at its accepting edge only
    assign wr_cmd = i_avs_write & ~st_q.avs_wait & (i_avs_address == ADDR_AUXCMD) & i_avs_byteenable[0];
    assign cmd    = i_avs_writedata[7:0];
    assign cs     = cmd[CMD_CS_BIT];
    assign fn     = cmd[CMD_FN_MSB:0];
    assign rsv_ok = (cmd[CMD_RSV_MSB:CMD_RSV_LSB] == 2'h0);
    assign pon    = st_q.stat.swrst;

    // forced trigger strobes for the stretcher
    assign fget_set = wr_cmd & rsv_ok & (fn == FN_FGET) & cs;
    assign fget_clr = wr_cmd & rsv_ok & (fn == FN_FGET) & ~cs;

    // flags are masked while software reset holds the functions idle
    assign la_flag = ~pon & (st_q.la | st_q.stat.lon);
    assign ta_flag = ~pon & (st_q.ta | st_q.stat.ton | i_evt.spas);

    // address status byte as software sees it
    always_comb
    begin
        status              = 8'h00;
        status[ST_REM_BIT]  = i_evt.rem;
        status[ST_LLO_BIT]  = i_evt.llo;
        status[ST_ATN_BIT]  = i_evt.atn;
        status[ST_LPAS_BIT] = st_q.lpas;
        status[ST_TALKER_PRIMARY_ADDRESSED_BIT] = st_q.talker_primary_addressed;
        status[ST_LA_BIT]   = la_flag;
        status[ST_TA_BIT]   = ta_flag;
        status[ST_ULPA_BIT] = st_q.ulpa;
    end

    // next state: bus slave, command decode, address flags
    always_comb
    begin
        st_d       = st_q;
        st_d.pulse = '0;    // pulses last one clock

        // one wait cycle, then a single cycle with waitrequest low
        if ((i_avs_read | i_avs_write) & st_q.avs_wait)
        begin
            st_d.avs_wait = 1'b0;
            st_d.rdata    = 32'h0000_0000;   // unmapped and write-only read zero
            unique case (i_avs_address)
                ADDR_STATUS: st_d.rdata[7:0]  = status;
                ADDR_STATIC: st_d.rdata[11:0] = st_q.stat;
                ADDR_PAGE:   st_d.rdata[3:0]  = st_q.page;
                default:     st_d.rdata       = 32'h0000_0000;
            endcase
        end
        else if (!st_q.avs_wait)
            st_d.avs_wait = 1'b1;

        // decode; statics only move on a matching write
        if (wr_cmd & rsv_ok)
        begin
            unique case (fn)
                FN_SWRST: st_d.stat.swrst = cs;
                FN_DAC:
                begin
                    st_d.pulse.dac_valid   = cs;
                    st_d.pulse.dac_invalid = ~cs;
                end
                FN_RHDF:  st_d.pulse.rhdf = ~cs;
                FN_HDFA:  st_d.stat.hdfa = cs;
                FN_HDFE:  st_d.stat.hdfe = cs;
                FN_NBAF:  st_d.pulse.nbaf = ~cs;
                FN_FGET:  st_d.stat.fget = cs;
                FN_RTL:
                begin
                    st_d.stat.rtl  = cs;
                    st_d.pulse.rtl = ~cs;                           // clear pulses the message true
                end
                FN_FEOI:  st_d.pulse.feoi = ~cs;
                FN_LON:
                begin
                    st_d.stat.lon = cs;
                    if (cs)
                        st_d.ta = 1'b0;
                end
                FN_TON:
                begin
                    st_d.stat.ton = cs;
                    if (cs)
                        st_d.la = 1'b0;
                end
                FN_DAI:   st_d.stat.dai = cs;
                FN_PTS:   st_d.pulse.pts = ~cs;
                FN_STDL:  st_d.stat.stdl = cs;
                FN_VSTDL: st_d.stat.vstdl = cs;
                FN_SERVICE_REQUEST_BIT_TWO:  st_d.stat.service_request_bit_two = cs;
                FN_ALT:   st_d.pulse.switch_alt_mode = cs;
                FN_REQ:
                begin
                    st_d.pulse.reqt = cs;
                    st_d.pulse.reqf = ~cs;
                end
                FN_CHRST:
                begin
                    st_d.pulse.chip_reset_cmd = ~cs;
                    st_d.pulse.clrpi          = cs;
                    if (cs)
                        st_d.page = '0;
                    else
                    begin
                        st_d.stat.swrst = 1'b1;                     // chip reset re-enters software reset
                        st_d.ulpa       = 1'b0;
                    end
                end
                FN_IST:   st_d.stat.ist = cs;
                FN_PIA:
                begin
                    st_d.pulse.pagein_mask_two = ~cs;
                    st_d.pulse.pagein_eos      = cs;
                    if (cs)
                        st_d.page.eos = 1'b1;
                    else
                        st_d.page.mask_two = 1'b1;
                end
                FN_PIB:
                begin
                    st_d.pulse.pagein_bus_ctrl  = ~cs;
                    st_d.pulse.pagein_accessory = cs;
                    if (cs)
                        st_d.page.accessory = 1'b1;
                    else
                        st_d.page.bus_ctrl = 1'b1;
                end
                default: st_d.pulse = '0;                           // reserved
            endcase
        end

        // primary lsb tracks every primary byte outside software reset; a new address wins over chip reset
        if (i_evt.pcg & ~pon)
            st_d.ulpa = i_evt.prim_lsb;

        // primary addressed states; pon holds them idle
        if (pon)
        begin
            st_d.talker_primary_addressed = 1'b0;
            st_d.lpas = 1'b0;
        end
        else
        begin
            if (i_evt.mta)
                st_d.talker_primary_addressed = 1'b1;
            else if (i_evt.pcg)
                st_d.talker_primary_addressed = 1'b0;
            if (i_evt.mla)
                st_d.lpas = 1'b1;
            else if (i_evt.pcg)
                st_d.lpas = 1'b0;
        end

        // listener addressed; talk addressing drops it
        if (pon | i_evt.ifc)
            st_d.la = 1'b0;
        else if (i_evt.mla)
            st_d.la = 1'b1;
        else if (i_evt.unl | i_evt.mta)
            st_d.la = 1'b0;

        // talker addressed; listen addressing drops it
        if (pon | i_evt.ifc)
            st_d.ta = 1'b0;
        else if (i_evt.mta)
            st_d.ta = 1'b1;
        else if (i_evt.ota | i_evt.mla)
            st_d.ta = 1'b0;
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
        begin
            st_q          <= '0;
            st_q.avs_wait <= 1'b1;
            st_q.stat     <= STATIC_RST;
        end
        else if (i_clk_en)
            st_q <= st_d;
    end

    // trigger pin driver
    iac_trig_stretch u_trig (
        .i_mclk   (i_mclk),
        .i_nrst   (i_nrst),
        .i_clk_en (i_clk_en),
        .i_set    (fget_set),
        .i_clr    (fget_clr),
        .o_trig   (o_trigger)
    );

    assign o_avs_readdata    = st_q.rdata;
    assign o_avs_waitrequest = st_q.avs_wait;
    assign o_static          = st_q.stat;
    assign o_pulse           = st_q.pulse;
    assign o_page            = st_q.page;

    // checks on the decoder and flags
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst || !i_clk_en);

    talker_primary_addressed_set_a: assert property (i_evt.mta && !pon |=> st_q.talker_primary_addressed)
        else $error("talk primary flag not set");
    talker_primary_addressed_clear_a: assert property (i_evt.pcg && !i_evt.mta |=> !st_q.talker_primary_addressed)
        else $error("talk primary flag not cleared");
    listen_drop_a: assert property (i_evt.mla && !pon && !i_evt.ifc |=> st_q.la && !st_q.ta)
        else $error("listen address did not drop talker");
    talk_drop_a: assert property (i_evt.mta && !pon && !i_evt.ifc |=> st_q.ta && !st_q.la)
        else $error("talk address did not drop listener");
    listen_clear_a: assert property (i_evt.ifc || (i_evt.unl && !i_evt.mla) |=> !st_q.la)
        else $error("listener flag not cleared");
    talk_clear_a: assert property (i_evt.ifc || (i_evt.ota && !i_evt.mta) |=> !st_q.ta)
        else $error("talker flag not cleared");
    ulpa_track_a: assert property (i_evt.pcg && !pon |=> st_q.ulpa == $past(i_evt.prim_lsb))
        else $error("primary lsb not captured");
    chip_reset_a: assert property (wr_cmd && cmd == {3'h0, FN_CHRST} && !i_evt.pcg
        |=> !st_q.ulpa && o_pulse.chip_reset_cmd ##1 !o_pulse.chip_reset_cmd)
        else $error("chip reset pulse or lsb clear wrong");
    static_write_a: assert property (wr_cmd && rsv_ok && fn == FN_LON
        |=> o_static.lon == $past(cs))
        else $error("static setting not taken from bit 7");
    one_pulse_a: assert property (wr_cmd && cmd == {3'h0, FN_NBAF} |=> o_pulse.nbaf ##1 !o_pulse.nbaf)
        else $error("pulsed command not one clock");
    reserved_a: assert property (wr_cmd && !rsv_ok |=> o_pulse == '0 && $stable(o_static))
        else $error("reserved code took action");
    idle_hold_a: assert property (pon |=> !st_q.la && !st_q.ta && !st_q.talker_primary_addressed)
        else $error("flags not idle under software reset");
    trig_pulse_a: assert property (fget_clr |=> o_trigger[*5])
        else $error("trigger pulse shorter than five clocks");
    bus_answer_a: assert property ((i_avs_read || i_avs_write) |-> ##[0:1] !o_avs_waitrequest)
        else $error("bus request not answered");

    cmd_write_c: cover property (wr_cmd && rsv_ok);
    trig_hold_c: cover property (fget_set ##[1:20] fget_clr);
    talk_addr_c: cover property (i_evt.mta && !pon ##1 st_q.talker_primary_addressed);
    status_read_c: cover property (i_avs_read && i_avs_address == ADDR_STATUS && !o_avs_waitrequest);

endmodule : iac_aux_cmd
`default_nettype wire

// ### sim/iac_host_model.sv
// host processor model driving the avalon command and status bus
`timescale 1ns/10ps
`default_nettype none
module iac_host_model
(
    input  wire logic        i_mclk,
    input  wire logic        i_wait,
    input  wire logic [31:0] i_rdata,
    output var logic         o_read,
    output var logic         o_write,
    output var logic  [3:0]  o_addr,
    output var logic  [31:0] o_wdata,
    output var logic  [3:0]  o_be,
    output var logic         o_tmo
);
    // bus idle from time zero
    initial
    begin
        {o_read, o_write, o_addr, o_wdata, o_be, o_tmo} = '0;
    end

    // one access: request held until waitrequest low stands at an edge
    task automatic access(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                          output logic [31:0] q);
        int n;
        repeat (3) @(posedge i_mclk);
        o_read  <= !wr;
        o_write <= wr;
        o_addr  <= a;
        o_wdata <= d;
        o_be    <= be;
        // waitrequest and read data are taken at the same rising edge
        for (n = 0; n < 50; n++)
        begin
            @(posedge i_mclk);
            if (!i_wait)
                break;
        end
        q = i_rdata;
        o_tmo   <= (n == 50);
        o_read  <= 1'b0;
        o_write <= 1'b0;
    endtask : access
endmodule : iac_host_model
`default_nettype wire

// ### sim/iac_aux_cmd_tb.sv
// self-checking bench of the auxiliary command decoder
`timescale 1ns/10ps
`default_nettype none
module iac_aux_cmd_tb import iac_pkg::*;;
    logic        mclk, nrst, rd, wr, wt, trig, tmo;
    logic [3:0]  addr, be;
    logic [31:0] wdat, rdat, q;
    iac_evt_s    evt;
    iac_static_s stat;
    iac_pulse_s  pulse;
    iac_page_s   page;
    int          fail_count = 0;
    int          num_checks = 0;

    iac_aux_cmd u_iac_aux_cmd (.i_mclk(mclk), .i_nrst(nrst), .i_clk_en(1'b1), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wt), .i_evt(evt), .o_static(stat), .o_pulse(pulse), .o_page(page), .o_trigger(trig));
    iac_host_model u_iac_host_model (.i_mclk(mclk), .i_wait(wt), .i_rdata(rdat), .o_read(rd), .o_write(wr),
        .o_addr(addr), .o_wdata(wdat), .o_be(be), .o_tmo(tmo));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    task automatic wcmd(input logic [7:0] c);
        u_iac_host_model.access(1'b1, ADDR_AUXCMD, {24'h0, c}, 4'h1, q);
    endtask : wcmd

    task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
        u_iac_host_model.access(1'b0, a, 32'h0, 4'hf, q);
        chk(q, exp);
    endtask : rchk

    // a pulsed code shows on its own bit for one cycle only
    task automatic pulse_chk(input logic [7:0] c, input int b);
        wcmd(c);
        @(negedge mclk);
        chk({16'h0, pulse}, 32'h1 << b);
        @(negedge mclk);
        chk({16'h0, pulse}, 32'h0);
    endtask : pulse_chk

    // one-cycle event strobe, then the status byte is read back
    task automatic ev(input logic [10:0] e, input logic [7:0] s);
        @(posedge mclk);
        evt <= e;
        @(posedge mclk);
        evt <= '0;
        rchk(ADDR_STATUS, {24'h0, s});
    endtask : ev

    task automatic t_reset;
        rchk(ADDR_STATIC, 32'h800);
        rchk(ADDR_PAGE, 32'h0);
        chk({31'h0, trig}, 32'h0);
        ev(11'h488, 8'h00);
    endtask : t_reset

    task automatic t_events;
        logic [10:0] e[8] = '{11'h488, 11'h280, 11'h480, 11'h100, 11'h288, 11'h040, 11'h288, 11'h020};
        logic [7:0]  s[8] = '{8'h0b, 8'h14, 8'h0a, 8'h08, 8'h15, 8'h11, 8'h15, 8'h11};
        wcmd(8'h00);
        for (int i = 0; i < 8; i++)
            ev(e[i], s[i]);
        pulse_chk(8'h1c, 5);
        rchk(ADDR_STATUS, 32'h0);
        rchk(ADDR_STATIC, 32'h800);
        wcmd(8'h00);
        wcmd(8'h89);
        rchk(ADDR_STATUS, 32'h04);
        wcmd(8'h09);
        wcmd(8'h8a);
        rchk(ADDR_STATUS, 32'h02);
        wcmd(8'h0a);
    endtask : t_events

    // every static code except software reset sets then clears its own flop, others untouched
    task automatic t_static;
        logic [7:0]  c[11] = '{8'h83, 8'h84, 8'h86, 8'h87, 8'h89, 8'h8a, 8'h93, 8'h95, 8'h97, 8'h98, 8'h9d};
        logic [31:0] x = 32'h0;
        for (int i = 0; i < 11; i++)
        begin
            wcmd(c[i]);
            x = x | (32'h1 << (10 - i));
            rchk(ADDR_STATIC, x);
        end
        for (int i = 0; i < 11; i++)
        begin
            wcmd(c[i] & 8'h7f);
            x = x & ~(32'h1 << (10 - i));
            rchk(ADDR_STATIC, x);
        end
    endtask : t_static

    task automatic t_pulses;
        logic [7:0] c[13] = '{8'h02, 8'h05, 8'h08, 8'h01, 8'h81, 8'h14, 8'h99, 8'h1a, 8'h9a, 8'h1e, 8'h1f, 8'h9e, 8'h9f};
        int         b[13] = '{13, 12, 11, 15, 14, 9, 8, 7, 6, 3, 2, 1, 0};
        for (int i = 0; i < 13; i++)
            pulse_chk(c[i], b[i]);
        rchk(ADDR_PAGE, 32'hf);
        pulse_chk(8'h9c, 4);
        chk({28'h0, page}, 32'h0);
    endtask : t_pulses

    // undefined codes and a write without lane 0 leave everything alone
    task automatic t_reserved;
        logic [7:0] c[6] = '{8'h0b, 8'ha0, 8'h82, 8'h9b, 8'h1b, 8'he9};
        for (int i = 0; i < 6; i++)
        begin
            wcmd(c[i]);
            @(negedge mclk);
            chk({16'h0, pulse}, 32'h0);
        end
        u_iac_host_model.access(1'b1, ADDR_AUXCMD, 32'h89, 4'h0, q);
        rchk(ADDR_STATIC, 32'h0);
        rchk(ADDR_AUXCMD, 32'h0);
    endtask : t_reserved

    task automatic t_trigger;
        int n = 0;
        wcmd(8'h86);
        repeat (12) @(negedge mclk);
        chk({31'h0, trig}, 32'h1);
        wcmd(8'h06);
        @(negedge mclk);
        while (trig === 1'b1 && n < 20)
        begin
            n++;
            @(negedge mclk);
        end
        chk(n, 5);
    endtask : t_trigger

    // free-running clock, 8 ns period
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // a bus wait that ran out ends the run
    always @(posedge tmo)
    begin
        fail_count++;
        test_done();
    end

    initial
    begin
        nrst = 1'b0;
        evt  = '0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
        t_events();
        t_static();
        t_pulses();
        t_reserved();
        t_trigger();
        test_done();
    end
endmodule : iac_aux_cmd_tb
`default_nettype wire
